// *** amd_consts.vh ***
// Constants for the addressing mode decoder
`ifndef AMD_CONSTS_VH
`define AMD_CONSTS_VH

// ------------------------------------------------------------
// Addressing classes (seven)
// ------------------------------------------------------------
`define AMD_CLS_INHERENT 3'h0
`define AMD_CLS_IMMEDIATE 3'h1
`define AMD_CLS_DIRECT 3'h2
`define AMD_CLS_INDEXED 3'h3
`define AMD_CLS_INDIRECT 3'h4
`define AMD_CLS_RELATIVE 3'h5
`define AMD_CLS_BITOP 3'h6

// ------------------------------------------------------------
// Addressing modes (seventeen)
// ------------------------------------------------------------
`define AMD_M_INH 5'h00
`define AMD_M_IMM 5'h01
`define AMD_M_SDIR 5'h02
`define AMD_M_LDIR 5'h03
`define AMD_M_NOIDX 5'h04
`define AMD_M_SIDX 5'h05
`define AMD_M_LIDX 5'h06
`define AMD_M_SIND 5'h07
`define AMD_M_LIND 5'h08
`define AMD_M_SINDX 5'h09
`define AMD_M_LINDX 5'h0a
`define AMD_M_REL 5'h0b
`define AMD_M_SINDREL 5'h0c
`define AMD_M_LINDREL 5'h0d
`define AMD_M_BITDIR 5'h0e
`define AMD_M_BITIND 5'h0f
`define AMD_M_BITREL 5'h10
`define AMD_MODE_COUNT 5'h11

// ------------------------------------------------------------
// Address ranges
// ------------------------------------------------------------
`define AMD_PAGE0_LAST 16'h00ff
`define AMD_PAGE0IDX_LAST 16'h01fe
`define AMD_FULL_LAST 16'hffff

// ------------------------------------------------------------
// Extra bytes and pointer sizes
// ------------------------------------------------------------
`define AMD_BYTES_W 2
`define AMD_PTR_NONE 2'h0
`define AMD_PTR_BYTE 2'h1
`define AMD_PTR_WORD 2'h2

// ------------------------------------------------------------
// Operation kinds
// ------------------------------------------------------------
`define AMD_OP_OTHER 4'h0
`define AMD_OP_CLEAR 4'h1
`define AMD_OP_COMPL 4'h2
`define AMD_OP_NEG 4'h3
`define AMD_OP_BSET 4'h4
`define AMD_OP_BCLR 4'h5
`define AMD_OP_TJ1 4'h6
`define AMD_OP_TJ0 4'h7
`define AMD_OP_ADD1 4'h8
`define AMD_OP_SUB1 4'h9
`define AMD_OP_RLC 4'ha
`define AMD_OP_RRC 4'hb
`define AMD_OP_SLL 4'hc
`define AMD_OP_SRL 4'hd
`define AMD_OP_SRA 4'he
`define AMD_OP_SWAP 4'hf

`endif

// *** amd_decode.v ***
// Registered addressing mode decoder between fetch and address generation
//
// How it works
// - Seventeen mode codes map onto seven addressing classes.
// - Long submodes except long indirect relative reach the whole 64 Kbyte space; long direct and indexed use more bytes.
// - Short submodes reach page zero, or up to 01fe when indexed, and never use more bytes.
// - Read-modify-write memory operations refuse every long addressing form.
// - No-offset indexed adds zero bytes with X, one with Y.
`include "amd_consts.vh"

module amd_decode (
	input wire mclk, // Core clock
	input wire nrst, // Synchronous reset, active low
	input wire req_valid, // Fetch offers a decoded mode
	input wire [4:0] req_mode, // Addressing mode code
	input wire req_use_y, // Second index register selected
	input wire [3:0] req_op, // Operation kind
	output reg dec_valid, // High one cycle after each request, answer ready
	output reg [2:0] dec_class, // Addressing class
	output reg [15:0] dec_range_last, // Highest reachable address
	output reg [1:0] dec_extra_bytes, // Extra instruction bytes
	output reg [1:0] dec_ptr_size, // Pointer size, none/byte/word
	output reg dec_long, // Long submode flag
	output reg dec_ptr_page0, // Pointer fetched from page zero
	output reg dec_illegal // Unknown mode or forbidden long form
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// True for operations that read, change and write memory
	function is_rmw;
		input [3:0] op;
		begin
			is_rmw = (op != `AMD_OP_OTHER);
		end
	endfunction

	// ------------------------------------------------------------
	// Table lookup
	// ------------------------------------------------------------
	wire [2:0] t_class;
	wire [15:0] t_range;
	wire [1:0] t_bytes;
	wire [1:0] t_ptr;
	wire t_long;
	wire t_known;

	amd_mode_table amd_mode_table_inst (
		.mode(req_mode),
		.use_y(req_use_y),
		.mode_class(t_class),
		.range_last(t_range),
		.extra_bytes(t_bytes),
		.ptr_size(t_ptr),
		.is_long(t_long),
		.known(t_known)
	);

	// ------------------------------------------------------------
	// Legality
	// ------------------------------------------------------------
	// unknown mode, or rmw op on a long form, refused
	wire next_illegal = !t_known || (is_rmw(req_op) && t_long);

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------
	// Answer one cycle after the request; refused forms zero the
	// range so address generation never starts a stray access
	always @(posedge mclk) begin
		if (!nrst) begin
			dec_valid <= 1'b0;
			dec_class <= `AMD_CLS_INHERENT;
			dec_range_last <= 16'h0000;
			dec_extra_bytes <= 2'h0;
			dec_ptr_size <= `AMD_PTR_NONE;
			dec_long <= 1'b0;
			dec_ptr_page0 <= 1'b0;
			dec_illegal <= 1'b0;
		end else begin
			dec_valid <= req_valid;
			if (req_valid) begin
				dec_class <= t_class;
				dec_range_last <= next_illegal ? 16'h0000 : t_range;
				dec_extra_bytes <= t_bytes;
				dec_ptr_size <= t_ptr;
				dec_long <= t_long;
				dec_ptr_page0 <= (t_ptr != `AMD_PTR_NONE);
				dec_illegal <= next_illegal;
			end
		end
	end

endmodule // amd_decode

// *** amd_decode_monitor.sv ***
// Port checker for the addressing mode decoder
module amd_decode_monitor (
	input wire mclk, // Clock
	input wire nrst, // Reset
	input wire req_valid, // Strobe
	input wire [4:0] req_mode, // Mode
	input wire req_use_y, // Y
	input wire [3:0] req_op, // Op
	input wire dec_valid, // Answer
	input wire [2:0] dec_class, // Class
	input wire [15:0] dec_range_last, // Range
	input wire [1:0] dec_extra_bytes, // Bytes
	input wire [1:0] dec_ptr_size, // Pointer
	input wire dec_long, // Long
	input wire dec_ptr_page0, // Page zero
	input wire dec_illegal // Refused
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Long forms other than long indirect relative that read-modify-write ops may not use
	wire lf = req_mode == 5'h03 || req_mode == 5'h06 || req_mode == 5'h08 || req_mode == 5'h0a;
	a_answer_next:
	assert property (req_valid |=> dec_valid) else $error("no answer");
	a_no_stray:
	assert property (!req_valid |=> !dec_valid) else $error("stray answer");
	a_unknown_mode:
	assert property (req_valid && req_mode > 5'h10 |=> dec_illegal) else $error("bad mode");
	a_long_full:
	assert property (req_valid && req_mode == 5'h03 && req_op == 4'h0 |=>
		dec_range_last == 16'hffff && dec_extra_bytes == 2'h2 && dec_long) else $error("long");
	a_short_page:
	assert property (req_valid && req_mode == 5'h02 |=> dec_range_last == 16'h00ff &&
		dec_extra_bytes == 2'h1 && !dec_long && !dec_illegal) else $error("short");
	a_rmw_long:
	assert property (req_valid && lf && req_op != 4'h0 |=> dec_illegal &&
		dec_range_last == 16'h0000) else $error("rmw long");
	a_noidx_bytes:
	assert property (req_valid && req_mode == 5'h04 |=>
		dec_extra_bytes == {1'b0, $past(req_use_y)}) else $error("noidx");
	a_ptr_page:
	assert property (req_valid && (req_mode == 5'h07 || req_mode == 5'h08) && req_op == 4'h0
		|=> dec_ptr_page0 && dec_extra_bytes == 2'h2 &&
		dec_ptr_size == ($past(req_mode[3]) ? 2'h2 : 2'h1)) else $error("pointer");
	c_rmw: cover property (req_valid && req_op != 4'h0 ##1 dec_illegal);
	c_b2b: cover property (dec_valid [*2]);
	c_ptr: cover property (dec_ptr_page0);
endmodule // amd_decode_monitor

bind amd_decode amd_decode_monitor mon (.mclk(mclk), .nrst(nrst), .req_valid(req_valid),
	.req_mode(req_mode), .req_use_y(req_use_y), .req_op(req_op), .dec_valid(dec_valid),
	.dec_class(dec_class), .dec_range_last(dec_range_last),
	.dec_extra_bytes(dec_extra_bytes), .dec_ptr_size(dec_ptr_size), .dec_long(dec_long),
	.dec_ptr_page0(dec_ptr_page0), .dec_illegal(dec_illegal));

// *** amd_decode_test.sv ***
// Self-checking bench for the addressing mode decoder
module amd_decode_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, nrst, req_valid, req_use_y, dec_valid, dec_long, dec_ptr_page0, dec_illegal;
	logic [4:0] req_mode;
	logic [3:0] req_op;
	logic [2:0] dec_class;
	logic [15:0] dec_range_last;
	logic [1:0] dec_extra_bytes, dec_ptr_size;
	logic [23:0] r;
	logic [2:0] cls [17] = '{0, 1, 2, 2, 3, 3, 3, 4, 4, 4, 4, 5, 5, 5, 6, 6, 6};
	logic [4:0] lm [4] = '{5'h03, 5'h06, 5'h08, 5'h0a};
	// Extra bytes and pointer size per mode code, with the first index register
	logic [1:0] xb [17] = '{0, 1, 1, 2, 0, 1, 2, 2, 2, 2, 2, 1, 2, 2, 1, 2, 2};
	logic [1:0] xp [17] = '{0, 0, 0, 0, 0, 0, 0, 1, 2, 1, 2, 0, 1, 2, 0, 1, 0};
	int error_cnt = 0;
	int check_count = 0;
	int cyc = 0;
	amd_fetch_model amd_fetch_model_inst (.req_valid(req_valid), .req_mode(req_mode),
		.req_use_y(req_use_y), .req_op(req_op));
	amd_decode amd_decode_inst (.mclk(mclk), .nrst(nrst), .req_valid(req_valid),
		.req_mode(req_mode), .req_use_y(req_use_y), .req_op(req_op), .dec_valid(dec_valid),
		.dec_class(dec_class), .dec_range_last(dec_range_last),
		.dec_extra_bytes(dec_extra_bytes), .dec_ptr_size(dec_ptr_size), .dec_long(dec_long),
		.dec_ptr_page0(dec_ptr_page0), .dec_illegal(dec_illegal));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// Hang guard, far above the some sixty cycles needed
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task wrap_up();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input string n, input logic [23:0] e, input logic [23:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	// Requests go back to back; answer seen one cycle on
	task ask(input logic [4:0] m, input logic y, input logic [3:0] o);
		amd_fetch_model_inst.put(m, y, o);
		@(negedge mclk);
		r = {dec_valid, dec_class, dec_range_last, dec_extra_bytes, dec_long, dec_illegal};
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_class();
		for (int i = 0; i < 17; i++) begin
			ask(5'(i), 1'b0, 4'h0);
			chk("class", {1'b1, cls[i]}, r[23:20]);
			chk("bytes", xb[i], r[3:2]);
			chk("pointer", {|xp[i], xp[i]}, {dec_ptr_page0, dec_ptr_size});
			chk("long", (i == 3 || i == 6 || i == 8 || i == 10 || i == 13), r[1]);
		end
		ask(5'h11, 1'b0, 4'h0);
		chk("unknown", 17'h1, {r[19:4], r[0]});
	endtask
	task t_direct();
		ask(5'h03, 1'b0, 4'h0);
		chk("long direct", {1'b1, 3'h2, 16'hffff, 2'h2, 2'b10}, r);
		ask(5'h06, 1'b0, 4'h0);
		chk("long index", {1'b1, 3'h3, 16'hffff, 2'h2, 2'b10}, r);
		ask(5'h02, 1'b0, 4'h0);
		chk("short direct", {1'b1, 3'h2, 16'h00ff, 2'h1, 2'b00}, r);
		ask(5'h05, 1'b0, 4'h0);
		chk("short index", {1'b1, 3'h3, 16'h01fe, 2'h1, 2'b00}, r);
	endtask
	task t_rmw();
		for (int o = 1; o < 16; o++) begin
			ask(lm[o % 4], 1'b0, 4'(o));
			chk("rmw long", 17'h1, {r[19:4], r[0]});
			ask(5'h02, 1'b0, 4'(o));
			chk("rmw short", 24'h0, {23'h0, r[0]});
		end
	endtask
	task t_noidx();
		ask(5'h04, 1'b0, 4'h0);
		chk("noidx x", {1'b1, 3'h3, 16'h00ff, 2'h0, 2'b00}, r);
		ask(5'h04, 1'b1, 4'h0);
		chk("noidx y", {1'b1, 3'h3, 16'h00ff, 2'h1, 2'b00}, r);
	endtask
	task t_ptr();
		ask(5'h07, 1'b0, 4'h0);
		chk("short ptr", 5'h16, {dec_ptr_page0, dec_ptr_size, dec_extra_bytes});
		ask(5'h08, 1'b0, 4'h0);
		chk("long ptr", 5'h1a, {dec_ptr_page0, dec_ptr_size, dec_extra_bytes});
		chk("long ind", {1'b1, 3'h4, 16'hffff, 2'h2, 2'b10}, r);
	endtask
	// Mid-run reset with a request on offer clears every answer field
	task t_reset();
		amd_fetch_model_inst.put(5'h08, 1'b0, 4'h0);
		nrst = 1'b0;
		@(negedge mclk);
		r = {dec_valid, dec_class, dec_range_last, dec_extra_bytes, dec_long, dec_illegal};
		chk("reset", 24'h0, r);
		chk("reset ptr", 24'h0, {dec_ptr_size, dec_ptr_page0});
		nrst = 1'b1;
		ask(5'h08, 1'b0, 4'h0);
		chk("after reset", {1'b1, 3'h4, 16'hffff, 2'h2, 2'b10}, r);
	endtask
	initial begin
		nrst = 1'b0;
		repeat (3) @(negedge mclk);
		nrst = 1'b1;
		t_class();
		t_direct();
		t_rmw();
		t_noidx();
		t_ptr();
		t_reset();
		amd_fetch_model_inst.stop();
		@(negedge mclk);
		chk("idle", 24'h0, {23'h0, dec_valid});
		wrap_up();
	end
endmodule // amd_decode_test

// *** amd_fetch_model.sv ***
// Fetch stage model offering addressing requests
module amd_fetch_model (
	output logic req_valid, // Strobe
	output logic [4:0] req_mode, // Mode
	output logic req_use_y, // Y
	output logic [3:0] req_op // Op
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		req_valid = 1'b0;
		req_mode = 5'h00;
		req_use_y = 1'b0;
		req_op = 4'h0;
	end
	// Called just after a falling edge
	task put(input logic [4:0] m, input logic y, input logic [3:0] o);
		req_valid = 1'b1;
		req_mode = m;
		req_use_y = y;
		req_op = o;
	endtask
	// Idle mode and op fields flip so stale values never look valid
	task stop();
		req_valid = 1'b0;
		req_mode = ~req_mode;
		req_op = ~req_op;
	endtask
endmodule // amd_fetch_model

// *** amd_mode_table.v ***
// Combinational table: mode to class, range, extra bytes, pointer
`include "amd_consts.vh"

module amd_mode_table (
	input wire [4:0] mode, // Addressing mode code
	input wire use_y, // Second index register chosen
	output reg [2:0] mode_class, // One of seven classes
	output reg [15:0] range_last, // Highest reachable address
	output reg [`AMD_BYTES_W-1:0] extra_bytes, // Operand bytes after opcode
	output reg [1:0] ptr_size, // Pointer size for indirect forms
	output reg is_long, // Long submode
	output reg known // Mode code is one of seventeen
);

	// ------------------------------------------------------------
	// Decode table
	// ------------------------------------------------------------
	// Defaults cover inherent; each case overrides what differs
	always @* begin
		mode_class = `AMD_CLS_INHERENT;
		range_last = 16'h0000;
		extra_bytes = 2'h0;
		ptr_size = `AMD_PTR_NONE;
		is_long = 1'b0;
		known = 1'b1;
		case (mode)
			`AMD_M_INH: begin
				mode_class = `AMD_CLS_INHERENT;
			end
			`AMD_M_IMM: begin
				mode_class = `AMD_CLS_IMMEDIATE;
				extra_bytes = 2'h1;
			end
			`AMD_M_SDIR: begin
				mode_class = `AMD_CLS_DIRECT;
				range_last = `AMD_PAGE0_LAST;
				extra_bytes = 2'h1;
			end
			`AMD_M_LDIR: begin
				mode_class = `AMD_CLS_DIRECT;
				range_last = `AMD_FULL_LAST;
				extra_bytes = 2'h2;
				is_long = 1'b1;
			end
			`AMD_M_NOIDX: begin
				mode_class = `AMD_CLS_INDEXED;
				range_last = `AMD_PAGE0_LAST;
				extra_bytes = use_y ? 2'h1 : 2'h0;
			end
			`AMD_M_SIDX: begin
				mode_class = `AMD_CLS_INDEXED;
				range_last = `AMD_PAGE0IDX_LAST;
				extra_bytes = 2'h1;
			end
			`AMD_M_LIDX: begin
				mode_class = `AMD_CLS_INDEXED;
				range_last = `AMD_FULL_LAST;
				extra_bytes = 2'h2;
				is_long = 1'b1;
			end
			`AMD_M_SIND: begin
				mode_class = `AMD_CLS_INDIRECT;
				range_last = `AMD_PAGE0_LAST;
				extra_bytes = 2'h2;
				ptr_size = `AMD_PTR_BYTE;
			end
			`AMD_M_LIND: begin
				mode_class = `AMD_CLS_INDIRECT;
				range_last = `AMD_FULL_LAST;
				extra_bytes = 2'h2;
				ptr_size = `AMD_PTR_WORD;
				is_long = 1'b1;
			end
			`AMD_M_SINDX: begin
				mode_class = `AMD_CLS_INDIRECT;
				range_last = `AMD_PAGE0IDX_LAST;
				extra_bytes = 2'h2;
				ptr_size = `AMD_PTR_BYTE;
			end
			`AMD_M_LINDX: begin
				mode_class = `AMD_CLS_INDIRECT;
				range_last = `AMD_FULL_LAST;
				extra_bytes = 2'h2;
				ptr_size = `AMD_PTR_WORD;
				is_long = 1'b1;
			end
			`AMD_M_REL: begin
				mode_class = `AMD_CLS_RELATIVE;
				extra_bytes = 2'h1;
			end
			`AMD_M_SINDREL: begin
				mode_class = `AMD_CLS_RELATIVE;
				range_last = `AMD_PAGE0_LAST;
				extra_bytes = 2'h2;
				ptr_size = `AMD_PTR_BYTE;
			end
			`AMD_M_LINDREL: begin
				mode_class = `AMD_CLS_RELATIVE;
				range_last = `AMD_PAGE0_LAST;
				extra_bytes = 2'h2;
				ptr_size = `AMD_PTR_WORD;
				is_long = 1'b1;
			end
			// Bit forms always target page zero
			`AMD_M_BITDIR: begin
				mode_class = `AMD_CLS_BITOP;
				range_last = `AMD_PAGE0_LAST;
				extra_bytes = 2'h1;
			end
			`AMD_M_BITIND: begin
				mode_class = `AMD_CLS_BITOP;
				range_last = `AMD_PAGE0_LAST;
				extra_bytes = 2'h2;
				ptr_size = `AMD_PTR_BYTE;
			end
			`AMD_M_BITREL: begin
				mode_class = `AMD_CLS_BITOP;
				range_last = `AMD_PAGE0_LAST;
				extra_bytes = 2'h2;
			end
			default: begin
				known = 1'b0;
			end
		endcase
	end

endmodule // amd_mode_table
